// ### design/usfl_pkg.sv
package usfl_pkg;

    localparam int          ADDR_W       = 2;
    localparam int          DATA_W       = 8;
    localparam int          CNT_W        = 4;

    // register offsets
    localparam logic [1:0]  OFF_STATUS   = 2'h0;
    localparam logic [1:0]  OFF_DATA     = 2'h1;
    localparam logic [1:0]  OFF_CTRL     = 2'h2;

    // status bit positions
    localparam int          BIT_TX_BUFFER_EMPTY     = 7;
    localparam int          BIT_TC       = 6;
    localparam int          BIT_RX_BUFFER_FULL     = 5;
    localparam int          BIT_IDLE     = 4;
    localparam int          BIT_OVR      = 3;
    localparam int          BIT_NF       = 2;
    localparam int          BIT_FE       = 1;
    localparam int          BIT_PF       = 0;

    // control bit positions
    localparam int          CTL_BRK      = 0;
    localparam int          CTL_PAR      = 1;
    localparam int          CTL_ILT      = 2;
    localparam int          CTL_NINE     = 3;
    localparam int          CTL_TXON     = 4;

    // reset values
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [7:0]  DATA_RST     = 8'h00;

    // idle character length in bit times
    localparam logic [3:0]  IDLE_BITS_8  = 4'hA;
    localparam logic [3:0]  IDLE_BITS_9  = 4'hB;

    typedef struct packed {
        logic       noise;
        logic       frame_bad;
        logic       parity_bad;
        logic [7:0] data;
    } usfl_rxchar_s;

    typedef struct packed {
        logic       tx_on;
        logic       nine_bit;
        logic       idle_count_select;
        logic       parity_enable;
        logic       queue_break_bit;
    } usfl_ctrl_s;

endpackage

// ### design/usfl_top.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps

module usfl_top
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // register port
    input  wire logic [1:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // transmitter side
    input  wire logic                  tx_load,
    input  wire logic                  tx_busy,
    output logic      [7:0]            tx_data,
    output logic                       tx_data_valid,
    // receiver side
    input  wire logic                  rx_pin,
    input  wire logic                  bit_tick,
    input  wire logic                  rx_start,
    input  wire logic                  rx_start_done,
    input  wire logic                  rx_stop_done,
    input  wire logic                  rx_xfer,
    input  wire usfl_pkg::usfl_rxchar_s rx_char,
    // control out
    output usfl_pkg::usfl_ctrl_s       ctrl
);

    function automatic logic hit(input logic [1:0] a, input logic [1:0] off);
        hit = (a == off);
    endfunction

    logic [7:0] status;
    logic       tx_buffer_empty_r;
    logic       tc_r;
    logic       rx_buffer_full_r;
    logic       idle_r;
    logic       ovr_r;
    logic       nf_r;
    logic       fe_r;
    logic       pf_r;
    logic [7:0] seen_r;
    logic       sts_rd_r;
    logic       tc_hold_r;
    logic [7:0] rx_data_r;
    logic [7:0] tx_data_r;
    logic [4:0] ctrl_r;
    logic [2:0] sync_r;
    logic       line_r;
    logic       armed_r;
    logic [3:0] cnt_r;
    logic       allow_r;

    logic st_rd;
    logic dat_rd;
    logic dat_wr;
    logic ctl_wr;
    logic txon_rise;
    logic brk_wr;
    logic tc_clr;
    logic rx_buffer_full_clr;
    logic accept;
    logic overrun;
    logic [3:0] idle_len;
    logic idle_hit;

    ////////////////////////////////////////////////////////////////////////
    // decode

    assign st_rd     = reg_rd && hit(reg_addr, usfl_pkg::OFF_STATUS);
    assign dat_rd    = reg_rd && hit(reg_addr, usfl_pkg::OFF_DATA);
    assign dat_wr    = reg_wr && hit(reg_addr, usfl_pkg::OFF_DATA);
    assign ctl_wr    = reg_wr && hit(reg_addr, usfl_pkg::OFF_CTRL);
    assign txon_rise = ctl_wr && reg_wdata[usfl_pkg::CTL_TXON]
                       && !ctrl_r[usfl_pkg::CTL_TXON];
    assign brk_wr    = ctl_wr && reg_wdata[usfl_pkg::CTL_BRK];
    assign tc_clr    = seen_r[usfl_pkg::BIT_TC]
                       && (dat_wr || txon_rise || brk_wr);
    assign rx_buffer_full_clr  = dat_rd && seen_r[usfl_pkg::BIT_RX_BUFFER_FULL];
    // a data read after a status read that saw the buffer full frees it in the same cycle, so the new one is kept
    assign overrun   = rx_xfer && rx_buffer_full_r && !rx_buffer_full_clr;
    assign accept    = rx_xfer && !overrun;

    assign status = {tx_buffer_empty_r, tc_r, rx_buffer_full_r, idle_r, ovr_r, nf_r, fe_r, pf_r};
    assign ctrl   = usfl_pkg::usfl_ctrl_s'(ctrl_r);
    assign tx_data       = tx_data_r;
    assign tx_data_valid = !tx_buffer_empty_r;

    ////////////////////////////////////////////////////////////////////////
    // register port; status has no write path at all

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (st_rd)
            reg_rdata <= status;
        else if (dat_rd)
            reg_rdata <= rx_data_r;
        else if (reg_rd && hit(reg_addr, usfl_pkg::OFF_CTRL))
            reg_rdata <= {3'h0, ctrl_r};
        else
            reg_rdata <= 8'h00;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl_r <= usfl_pkg::CTRL_RST[4:0];
        else if (ctl_wr)
            ctrl_r <= reg_wdata[4:0];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tx_data_r <= usfl_pkg::DATA_RST;
        else if (dat_wr)
            tx_data_r <= reg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // status-read record

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            seen_r   <= 8'h00;
            sts_rd_r <= 1'b0;
        end
        else if (st_rd)
        begin
            seen_r   <= status;
            sts_rd_r <= 1'b1;
        end
        else
        begin
            if (dat_rd)
            begin
                seen_r[5:0] <= 6'h00;
                sts_rd_r    <= 1'b0;
            end
            if (dat_wr)
                seen_r[usfl_pkg::BIT_TX_BUFFER_EMPTY] <= 1'b0;
            if (tc_clr)
                seen_r[usfl_pkg::BIT_TC] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit flags

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tx_buffer_empty_r <= 1'b1;
        else if (tx_load)
            tx_buffer_empty_r <= 1'b1;
        else if (dat_wr && seen_r[usfl_pkg::BIT_TX_BUFFER_EMPTY])
            tx_buffer_empty_r <= 1'b0;
    end

    // hold keeps tc low until the queued activity shows as busy
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tc_hold_r <= 1'b0;
        else if (tc_clr)
            tc_hold_r <= 1'b1;
        else if (tx_busy)
            tc_hold_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tc_r <= 1'b1;
        else if (tc_clr)
            tc_r <= 1'b0;
        else if (tx_buffer_empty_r && !tx_busy && !tc_hold_r)
            tc_r <= 1'b1;
        else if (tx_busy)
            tc_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // receive flags; a new event wins over a clear in the same cycle

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rx_data_r <= usfl_pkg::DATA_RST;
        else if (accept)
            rx_data_r <= rx_char.data;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rx_buffer_full_r <= 1'b0;
        else if (accept)
            rx_buffer_full_r <= 1'b1;
        else if (rx_buffer_full_clr)
            rx_buffer_full_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ovr_r <= 1'b0;
        else if (overrun)
            ovr_r <= 1'b1;
        else if (dat_rd && seen_r[usfl_pkg::BIT_OVR])
            ovr_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            nf_r <= 1'b0;
        else if (accept)
            nf_r <= rx_char.noise;
        else if (dat_rd && sts_rd_r)
            nf_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            fe_r <= 1'b0;
        else if (accept)
            fe_r <= rx_char.frame_bad;
        else if (dat_rd && seen_r[usfl_pkg::BIT_FE])
            fe_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pf_r <= 1'b0;
        else if (accept)
            pf_r <= rx_char.parity_bad
                    && ctrl_r[usfl_pkg::CTL_PAR];
        else if (dat_rd && sts_rd_r)
            pf_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // line synchroniser and idle detection

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_r <= 3'h7;
            line_r <= 1'b1;
        end
        else
        begin
            sync_r <= {sync_r[1:0], rx_pin};
            if (sync_r[1] == sync_r[2])
                line_r <= sync_r[2];
        end
    end

    assign idle_len = ctrl_r[usfl_pkg::CTL_NINE] ? usfl_pkg::IDLE_BITS_9
                                                 : usfl_pkg::IDLE_BITS_8;
    assign idle_hit = armed_r && (cnt_r == idle_len);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            armed_r <= 1'b0;
            cnt_r   <= 4'h0;
        end
        else if (rx_start)
        begin
            armed_r <= 1'b0;
            cnt_r   <= 4'h0;
        end
        else if (ctrl_r[usfl_pkg::CTL_ILT] ? rx_stop_done
                                          : rx_start_done)
        begin
            armed_r <= 1'b1;
            cnt_r   <= 4'h0;
        end
        else if (!line_r)
            cnt_r <= 4'h0;
        else if (armed_r && bit_tick && cnt_r != idle_len)
            cnt_r <= cnt_r + 4'h1;
    end

    // only a fresh character rearms, so a long idle sets the flag once
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            allow_r <= 1'b0;
        else if (accept)
            allow_r <= 1'b1;
        else if (idle_hit)
            allow_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            idle_r <= 1'b0;
        else if (idle_hit && allow_r)
            idle_r <= 1'b1;
        else if (dat_rd && seen_r[usfl_pkg::BIT_IDLE])
            idle_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    property p_st_wr;
        @(posedge clk) disable iff (sys_rst)
        reg_wr && hit(reg_addr, usfl_pkg::OFF_STATUS) && rx_buffer_full_r && !rx_xfer
        |=> rx_buffer_full_r;
    endproperty
    a_st_wr: assert property (p_st_wr) else $error("status write hit flag");

    property p_tx_buffer_empty_set;
        @(posedge clk) disable iff (sys_rst) tx_load |=> tx_buffer_empty_r && !tx_data_valid;
    endproperty
    a_tx_buffer_empty_set: assert property (p_tx_buffer_empty_set) else $error("tx_buffer_empty not set");

    property p_tx_buffer_empty_clr;
        @(posedge clk) disable iff (sys_rst)
        st_rd && tx_buffer_empty_r ##1 dat_wr && !tx_load |=> !tx_buffer_empty_r;
    endproperty
    a_tx_buffer_empty_clr: assert property (p_tx_buffer_empty_clr) else $error("tx_buffer_empty not cleared");

    property p_tc_clr;
        @(posedge clk) disable iff (sys_rst) tc_clr |=> !tc_r;
    endproperty
    a_tc_clr: assert property (p_tc_clr) else $error("tc not cleared");

    property p_rx_buffer_full;
        @(posedge clk) disable iff (sys_rst)
        accept |=> rx_buffer_full_r && rx_data_r == $past(rx_char.data);
    endproperty
    a_rx_buffer_full: assert property (p_rx_buffer_full) else $error("rx char not taken");

    property p_rx_buffer_full_clr;
        @(posedge clk) disable iff (sys_rst)
        st_rd && rx_buffer_full_r ##1 dat_rd && !rx_xfer |=> !rx_buffer_full_r;
    endproperty
    a_rx_buffer_full_clr: assert property (p_rx_buffer_full_clr) else $error("rx_buffer_full not cleared");

    property p_ovr;
        @(posedge clk) disable iff (sys_rst) overrun |=> ovr_r && $stable(rx_data_r);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun mishandled");

    property p_idle_once;
        @(posedge clk) disable iff (sys_rst) !allow_r && !idle_r && !accept |=> !idle_r;
    endproperty
    a_idle_once: assert property (p_idle_once) else $error("idle set again");

    property p_pf_off;
        @(posedge clk) disable iff (sys_rst)
        accept && !ctrl_r[usfl_pkg::CTL_PAR] |=> !pf_r;
    endproperty
    a_pf_off: assert property (p_pf_off) else $error("parity flag while off");

    property p_fe_keep;
        @(posedge clk) disable iff (sys_rst)
        dat_rd && fe_r && !seen_r[usfl_pkg::BIT_FE] && !accept |=> fe_r;
    endproperty
    a_fe_keep: assert property (p_fe_keep) else $error("fe cleared unseen");

    c_ovr:  cover property (@(posedge clk) disable iff (sys_rst) overrun);
    c_idle: cover property (@(posedge clk) disable iff (sys_rst) $rose(idle_r));
    c_tcon: cover property (@(posedge clk) disable iff (sys_rst) tc_clr && txon_rise);
    c_tx_buffer_empty: cover property (@(posedge clk) disable iff (sys_rst) $fell(tx_buffer_empty_r));

endmodule // usfl_top

// ### verification/usfl_partner.sv
`timescale 1ns/1ps

module usfl_partner
(
    // clock
    input  wire logic               clk,
    // transmitter side
    output logic                    tx_load,
    output logic                    tx_busy,
    // receiver side
    output logic                    rx_pin,
    output logic                    bit_tick,
    output logic                    rx_start,
    output logic                    rx_start_done,
    output logic                    rx_stop_done,
    output logic                    rx_xfer,
    output usfl_pkg::usfl_rxchar_s  rx_char
);

    initial
    begin
        {tx_load, tx_busy, bit_tick, rx_start} = 4'h0;
        {rx_start_done, rx_stop_done, rx_xfer} = 3'h0;
        rx_pin  = 1'b1;
        rx_char = 11'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shifter takes the buffered byte, stays busy for a while
    task automatic send_tx(input int len);
        @(posedge clk);
        tx_busy <= 1'b1;
        tx_load <= 1'b1;
        @(posedge clk);
        tx_load <= 1'b0;
        repeat (len) @(posedge clk);
        tx_busy <= 1'b0;
    endtask

    // bit times with the line high
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clk);
            bit_tick <= 1'b1;
            @(posedge clk);
            bit_tick <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // one frame; k high bit times inside it, error bits ride with the transfer
    task automatic send_char(input logic [7:0] d, input logic nz, input logic fr,
                             input logic pb, input int k);
        @(posedge clk);
        rx_pin   <= 1'b0;
        rx_start <= 1'b1;
        @(posedge clk);
        rx_start <= 1'b0;
        repeat (6) @(posedge clk);
        rx_pin        <= 1'b1;
        rx_start_done <= 1'b1;
        @(posedge clk);
        rx_start_done <= 1'b0;
        repeat (4) @(posedge clk);
        ticks(k);
        @(posedge clk);
        rx_stop_done <= 1'b1;
        @(posedge clk);
        rx_stop_done <= 1'b0;
        rx_xfer      <= 1'b1;
        rx_char      <= {nz, fr, pb, d};
        @(posedge clk);
        rx_xfer <= 1'b0;
        // stale payload never left looking valid
        rx_char <= ~rx_char;
    endtask

endmodule // usfl_partner

// ### verification/tb.sv
`timescale 1ns/1ps

module tb;

    logic                    clk;
    logic                    sys_rst;
    logic [1:0]              reg_addr;
    logic [7:0]              reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [7:0]              reg_rdata;
    logic [7:0]              tx_data;
    logic                    tx_data_valid;
    logic                    tx_load;
    logic                    tx_busy;
    logic                    rx_pin;
    logic                    bit_tick;
    logic                    rx_start;
    logic                    rx_start_done;
    logic                    rx_stop_done;
    logic                    rx_xfer;
    usfl_pkg::usfl_rxchar_s  rx_char;
    usfl_pkg::usfl_ctrl_s    ctrl;
    int                      errors;
    int                      samples_checked;
    logic [7:0]              v;

    usfl_top u_usfl_top (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_load(tx_load), .tx_busy(tx_busy), .tx_data(tx_data),
        .tx_data_valid(tx_data_valid), .rx_pin(rx_pin), .bit_tick(bit_tick),
        .rx_start(rx_start), .rx_start_done(rx_start_done), .rx_stop_done(rx_stop_done),
        .rx_xfer(rx_xfer), .rx_char(rx_char), .ctrl(ctrl));

    usfl_partner u_usfl_partner (.clk(clk), .tx_load(tx_load), .tx_busy(tx_busy),
        .rx_pin(rx_pin), .bit_tick(bit_tick), .rx_start(rx_start),
        .rx_start_done(rx_start_done), .rx_stop_done(rx_stop_done), .rx_xfer(rx_xfer),
        .rx_char(rx_char));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic st(input logic [7:0] m, input logic [7:0] e);
        rd(usfl_pkg::OFF_STATUS, v);
        check("status", v & m, e);
    endtask

    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // run takes a few hundred cycles
    initial
    begin
        #100us;
        errors++;
        give_verdict;
    end

    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 12'h0;
        errors          = 0;
        samples_checked = 0;
        sys_rst         = 1'b1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        // transmit side
        st(8'hFF, 8'hC0);
        check("valid", {7'h0, tx_data_valid}, 8'h00);
        check("ctrl", {3'h0, ctrl}, 8'h00);
        rd(2'h3, v);
        check("unmapped", v, 8'h00);
        wr(usfl_pkg::OFF_STATUS, 8'h00);
        st(8'hFF, 8'hC0);
        wr(usfl_pkg::OFF_DATA, 8'h5A);
        check("tx_data", tx_data, 8'h5A);
        check("valid", {7'h0, tx_data_valid}, 8'h01);
        st(8'hC0, 8'h00);
        u_usfl_partner.send_tx(3);
        st(8'hC0, 8'hC0);
        wr(usfl_pkg::OFF_DATA, 8'h33);
        u_usfl_partner.send_tx(3);
        wr(usfl_pkg::OFF_DATA, 8'h77);
        check("valid", {7'h0, tx_data_valid}, 8'h00);
        st(8'hC0, 8'hC0);
        wr(usfl_pkg::OFF_CTRL, 8'h10);
        check("ctrl", {3'h0, ctrl}, 8'h10);
        st(8'hC0, 8'h80);
        u_usfl_partner.send_tx(3);
        st(8'hC0, 8'hC0);
        wr(usfl_pkg::OFF_CTRL, 8'h11);
        st(8'hC0, 8'h80);
        $display("test transmit flags done");
        // receive side, parity off then on
        wr(usfl_pkg::OFF_CTRL, 8'h00);
        u_usfl_partner.send_char(8'hA5, 1'b1, 1'b0, 1'b1, 0);
        st(8'h3F, 8'h24);
        rd(usfl_pkg::OFF_DATA, v);
        check("rx data", v, 8'hA5);
        st(8'h3F, 8'h00);
        wr(usfl_pkg::OFF_CTRL, 8'h02);
        u_usfl_partner.send_char(8'h3C, 1'b0, 1'b1, 1'b1, 0);
        st(8'h3F, 8'h23);
        u_usfl_partner.send_char(8'hFF, 1'b1, 1'b1, 1'b1, 0);
        st(8'h3F, 8'h2B);
        rd(usfl_pkg::OFF_DATA, v);
        check("rx data", v, 8'h3C);
        st(8'h3F, 8'h00);
        u_usfl_partner.send_char(8'h11, 1'b0, 1'b0, 1'b0, 0);
        rd(usfl_pkg::OFF_DATA, v);
        st(8'h3F, 8'h20);
        rd(usfl_pkg::OFF_DATA, v);
        check("rx data", v, 8'h11);
        st(8'h3F, 8'h00);
        $display("test receive flags done");
        // idle from after start bit, eight-bit characters
        wr(usfl_pkg::OFF_CTRL, 8'h00);
        u_usfl_partner.send_char(8'hF0, 1'b0, 1'b0, 1'b0, 4);
        u_usfl_partner.ticks(5);
        repeat (3) @(posedge clk);
        st(8'h10, 8'h00);
        u_usfl_partner.ticks(1);
        repeat (3) @(posedge clk);
        st(8'h10, 8'h10);
        rd(usfl_pkg::OFF_DATA, v);
        st(8'h30, 8'h00);
        u_usfl_partner.ticks(12);
        repeat (3) @(posedge clk);
        st(8'h10, 8'h00);
        // idle from after stop bit, nine-bit characters
        wr(usfl_pkg::OFF_CTRL, 8'h0C);
        u_usfl_partner.send_char(8'hFF, 1'b0, 1'b0, 1'b0, 4);
        u_usfl_partner.ticks(10);
        repeat (3) @(posedge clk);
        st(8'h10, 8'h00);
        u_usfl_partner.ticks(1);
        repeat (3) @(posedge clk);
        st(8'h10, 8'h10);
        $display("test idle flag done");
        // reset again in mid-run: every flag and register back to its reset value
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        st(8'hFF, 8'hC0);
        check("valid", {7'h0, tx_data_valid}, 8'h00);
        check("ctrl", {3'h0, ctrl}, 8'h00);
        $display("test second reset done");
        give_verdict;
    end

endmodule // tb
